// File: core/coa_pkg.sv
// Shared constants and types for the CPU operand addressing block.
package coa_pkg;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 16;
    localparam int BANK_W  = 2;
    localparam int REG_SEL_W = 3;

    // Address map boundaries of the internal data space.
    localparam logic [7:0] SPECIAL_REGS_BASE = 8'h80;
    localparam logic [7:0] BIT_IRAM_BASE     = 8'h20;

    // Opcodes whose operand does not follow the regular column pattern.
    localparam logic [7:0] OP_INC_ACC    = 8'h04;
    localparam logic [7:0] OP_DEC_ACC    = 8'h14;
    localparam logic [7:0] OP_JBC        = 8'h10;
    localparam logic [7:0] OP_JB         = 8'h20;
    localparam logic [7:0] OP_JNB        = 8'h30;
    localparam logic [7:0] OP_ORL_C_BIT  = 8'h72;
    localparam logic [7:0] OP_ANL_C_BIT  = 8'h82;
    localparam logic [7:0] OP_MOVC_PC    = 8'h83;
    localparam logic [7:0] OP_DIV        = 8'h84;
    localparam logic [7:0] OP_MOV_DP_IMM = 8'h90;
    localparam logic [7:0] OP_MOV_BIT_C  = 8'h92;
    localparam logic [7:0] OP_MOVC_DP    = 8'h93;
    localparam logic [7:0] OP_ORL_C_NBIT = 8'hA0;
    localparam logic [7:0] OP_MOV_C_BIT  = 8'hA2;
    localparam logic [7:0] OP_MUL        = 8'hA4;
    localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
    localparam logic [7:0] OP_CPL_BIT    = 8'hB2;
    localparam logic [7:0] OP_CPL_C      = 8'hB3;
    localparam logic [7:0] OP_CJNE_IMM   = 8'hB4;
    localparam logic [7:0] OP_CLR_BIT    = 8'hC2;
    localparam logic [7:0] OP_CLR_C      = 8'hC3;
    localparam logic [7:0] OP_SWAP       = 8'hC4;
    localparam logic [7:0] OP_SETB_BIT   = 8'hD2;
    localparam logic [7:0] OP_SETB_C     = 8'hD3;
    localparam logic [7:0] OP_DA         = 8'hD4;
    localparam logic [7:0] OP_MOVX_RD_DP = 8'hE0;
    localparam logic [7:0] OP_CLR_ACC    = 8'hE4;
    localparam logic [7:0] OP_MOVX_WR_DP = 8'hF0;
    localparam logic [7:0] OP_CPL_ACC    = 8'hF4;

    // Opcode column and row fields.
    localparam logic [3:0] COL_IMM_ACC   = 4'h4;
    localparam logic [3:0] COL_DIRECT    = 4'h5;
    localparam logic [3:0] COL_MOVX_RI   = 4'h2;
    localparam logic [2:0] COL_INDIRECT  = 3'b011;
    localparam logic [3:0] ROW_MOVX_RD   = 4'hE;
    localparam logic [3:0] ROW_MOVX_WR   = 4'hF;

    // Cycle counts issued per addressing mode.
    localparam logic [1:0] CYC_SHORT = 2'h1;
    localparam logic [1:0] CYC_LONG  = 2'h2;
    localparam logic [1:0] CYC_RMW   = 2'h3;

    typedef enum logic [3:0] {
        COA_MODE_IMPLIED,
        COA_MODE_DIRECT,
        COA_MODE_INDIRECT8,
        COA_MODE_INDIRECT16,
        COA_MODE_REGISTER,
        COA_MODE_REG_SPECIFIC,
        COA_MODE_IMMEDIATE,
        COA_MODE_INDEXED,
        COA_MODE_BIT
    } coa_mode_t;

    typedef enum logic [2:0] {
        COA_SPACE_NONE,
        COA_SPACE_IRAM,
        COA_SPACE_SFR,
        COA_SPACE_XDATA,
        COA_SPACE_CODE,
        COA_SPACE_ACC,
        COA_SPACE_CARRY
    } coa_space_t;

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic [ADDR_W-1:0] data_pointer;
        logic [ADDR_W-1:0] pc;
        logic [BANK_W-1:0] bank;
        logic [DATA_W-1:0] index_reg_zero;
        logic [DATA_W-1:0] index_reg_one;
    } coa_cpu_state_t;

    typedef struct packed {
        coa_mode_t         mode;
        coa_space_t        space;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] imm;
        logic [2:0]        bit_idx;
        logic [1:0]        cycles;
    } coa_operand_t;
endpackage : coa_pkg

// File: core/coa_reset_ctrl.sv
// External reset pin and optional alternate reset pin combiner.
`timescale 1ns/1ps
module coa_reset_ctrl (
    // Clock and power-on reset
    input  wire logic I_CLK_SYS,
    input  wire logic I_RST,
    // Reset pins
    input  wire logic i_ext_reset_n,
    input  wire logic i_alt_reset_n,
    input  wire logic i_alt_reset_en,
    // Combined synchronous reset
    output logic      o_core_reset
);
    logic [1:0] ext_sync;
    logic [1:0] alt_sync;
    logic       alt_en;

    // The pin idles high through its pull-up, so an undriven pin keeps the core running.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            ext_sync <= 2'h3;
            alt_sync <= 2'h3;
        end else begin
            ext_sync <= {ext_sync[0], i_ext_reset_n};
            alt_sync <= {alt_sync[0], i_alt_reset_n};
        end
    end

    // The nonvolatile option is caught after release, never under the asynchronous reset.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            alt_en <= 1'b0;
        end else begin
            alt_en <= i_alt_reset_en;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= !ext_sync[1] || (alt_en && !alt_sync[1]);
        end
    end
endmodule : coa_reset_ctrl

// File: core/coa_operand_decoder.sv
// Operand addressing decoder of the pipelined 8-bit CPU core.
//
// Summary of operation
// - Direct mode uses 8-bit field, RAM/registers only.
// - 8-bit indirect uses index register zero/one.
// - 16-bit indirect uses the data pointer.
// - Register mode picks one of eight from opcode.
// - Register-specific instructions use implied accumulator or carry operand.
// - Immediate bytes are values; only the 16-bit pointer load also puts them in the address field.
// - Indexed reads code at data pointer or program counter plus accumulator.
// - Bit mode selects one of 256 bits.
// - Most instructions take one or two cycles.
// - Classic instruction encodings decoded unchanged.
// - Active-low external reset with pull-up.
// - Alternate pin may act as external reset.
`timescale 1ns/1ps
module coa_operand_decoder #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic                       I_CLK_SYS,
    input  wire logic                       I_RST,
    // Reset pins
    input  wire logic                       I_EXT_RESET_N,
    input  wire logic                       I_ALT_RESET_N,
    input  wire logic                       I_ALT_RESET_EN,
    // Instruction bytes
    input  wire logic                       I_VALID,
    input  wire logic [7:0]                 I_OPCODE,
    input  wire logic [7:0]                 I_BYTE1,
    input  wire logic [7:0]                 I_BYTE2,
    // Architectural state
    input  wire coa_pkg::coa_cpu_state_t    I_STATE,
    // Decoded operand
    output logic                            O_VALID,
    output coa_pkg::coa_operand_t           O_OPERAND,
    output logic                            O_CORE_RESET
);
    // The combiner is written for a two-stage chain; deeper chains would only add latency.
    if (SYNC_STAGES != 2) begin : g_bad_sync
        $error("coa_operand_decoder: only two synchroniser stages are built");
    end

    // The register window and the pointer field assume classic byte and address sizes.
    if (coa_pkg::DATA_W != 8 || coa_pkg::ADDR_W != 16 || coa_pkg::BANK_W != 2) begin : g_width
        $error("coa_operand_decoder: operand fields need 8-bit data and 16-bit addresses");
    end

    logic                  core_reset;
    coa_pkg::coa_operand_t next_operand;
    logic [7:0]            ri;

    coa_reset_ctrl coa_reset_ctrl_inst (
        .I_CLK_SYS      (I_CLK_SYS),
        .I_RST          (I_RST),
        .i_ext_reset_n  (I_EXT_RESET_N),
        .i_alt_reset_n  (I_ALT_RESET_N),
        .i_alt_reset_en (I_ALT_RESET_EN),
        .o_core_reset   (core_reset)
    );

    // Direct addresses below the register window land in RAM, the rest in the registers.
    function automatic coa_pkg::coa_space_t direct_space(input logic [7:0] a);
        direct_space = (a < coa_pkg::SPECIAL_REGS_BASE) ? coa_pkg::COA_SPACE_IRAM
                                                : coa_pkg::COA_SPACE_SFR;
    endfunction : direct_space

    // Low bit addresses map onto a 16-byte RAM area, high ones onto aligned registers.
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        if (b < coa_pkg::SPECIAL_REGS_BASE) begin
            bit_byte = coa_pkg::BIT_IRAM_BASE + {4'h0, b[6:3]};
        end else begin
            bit_byte = {b[7:3], 3'b000};
        end
    endfunction : bit_byte

    // Every single-bit instruction carries its bit address in the first byte.
    function automatic logic is_bit_op(input logic [7:0] op);
        unique case (op)
            coa_pkg::OP_JBC, coa_pkg::OP_JB, coa_pkg::OP_JNB,
            coa_pkg::OP_ORL_C_BIT, coa_pkg::OP_ANL_C_BIT, coa_pkg::OP_MOV_BIT_C,
            coa_pkg::OP_ORL_C_NBIT, coa_pkg::OP_ANL_C_NBIT, coa_pkg::OP_MOV_C_BIT,
            coa_pkg::OP_CPL_BIT, coa_pkg::OP_CLR_BIT, coa_pkg::OP_SETB_BIT: is_bit_op = 1'b1;
            default: is_bit_op = 1'b0;
        endcase
    endfunction : is_bit_op

    // These instructions always work on the accumulator and name no operand.
    function automatic logic is_acc_op(input logic [7:0] op);
        unique case (op)
            coa_pkg::OP_INC_ACC, coa_pkg::OP_DEC_ACC, coa_pkg::OP_DIV, coa_pkg::OP_MUL,
            coa_pkg::OP_SWAP, coa_pkg::OP_DA, coa_pkg::OP_CLR_ACC,
            coa_pkg::OP_CPL_ACC: is_acc_op = 1'b1;
            default: is_acc_op = 1'b0;
        endcase
    endfunction : is_acc_op

    // Carry-flag instructions name no operand at all.
    function automatic logic is_carry_op(input logic [7:0] op);
        unique case (op)
            coa_pkg::OP_CPL_C, coa_pkg::OP_CLR_C, coa_pkg::OP_SETB_C: is_carry_op = 1'b1;
            default: is_carry_op = 1'b0;
        endcase
    endfunction : is_carry_op

    // External-data moves through the data pointer reach the full 16-bit space.
    function automatic logic is_movx_dp(input logic [7:0] op);
        is_movx_dp = op == coa_pkg::OP_MOVX_RD_DP || op == coa_pkg::OP_MOVX_WR_DP;
    endfunction : is_movx_dp

    // External-data moves through an index register sit in columns 2 and 3 of rows E and F.
    function automatic logic is_movx_ri(input logic [7:0] op);
        is_movx_ri = (op[7:4] == coa_pkg::ROW_MOVX_RD || op[7:4] == coa_pkg::ROW_MOVX_WR)
                     && op[3:1] == coa_pkg::COL_MOVX_RI[3:1];
    endfunction : is_movx_ri

    // Working register n of bank b sits at byte eight times b plus n of internal RAM.
    function automatic logic [15:0] reg_window(input logic [1:0] b, input logic [2:0] n);
        reg_window = {11'h000, b, n};
    endfunction : reg_window

    // Bit zero of the opcode picks which index register points at the operand.
    assign ri = I_OPCODE[0] ? I_STATE.index_reg_one : I_STATE.index_reg_zero;

    // Opcode classification follows the classic encoding table column by column.
    always_comb begin
        next_operand         = '0;
        next_operand.mode    = coa_pkg::COA_MODE_IMPLIED;
        next_operand.space   = coa_pkg::COA_SPACE_NONE;
        next_operand.cycles  = coa_pkg::CYC_SHORT;
        if (is_movx_dp(I_OPCODE)) begin
            next_operand.mode   = coa_pkg::COA_MODE_INDIRECT16;
            next_operand.space  = coa_pkg::COA_SPACE_XDATA;
            next_operand.addr   = I_STATE.data_pointer;
            next_operand.cycles = coa_pkg::CYC_LONG;
        end else if (is_movx_ri(I_OPCODE)) begin
            next_operand.mode   = coa_pkg::COA_MODE_INDIRECT8;
            next_operand.space  = coa_pkg::COA_SPACE_XDATA;
            next_operand.addr   = {8'h00, ri};
            next_operand.cycles = coa_pkg::CYC_LONG;
        end else if (I_OPCODE == coa_pkg::OP_MOVC_DP) begin
            // Only a read of program memory can use this form.
            next_operand.mode   = coa_pkg::COA_MODE_INDEXED;
            next_operand.space  = coa_pkg::COA_SPACE_CODE;
            next_operand.addr   = I_STATE.data_pointer + {8'h00, I_STATE.acc};
            next_operand.cycles = coa_pkg::CYC_LONG;
        end else if (I_OPCODE == coa_pkg::OP_MOVC_PC) begin
            next_operand.mode   = coa_pkg::COA_MODE_INDEXED;
            next_operand.space  = coa_pkg::COA_SPACE_CODE;
            next_operand.addr   = I_STATE.pc + {8'h00, I_STATE.acc};
            next_operand.cycles = coa_pkg::CYC_LONG;
        end else if (I_OPCODE == coa_pkg::OP_MOV_DP_IMM) begin
            next_operand.mode   = coa_pkg::COA_MODE_IMMEDIATE;
            next_operand.addr   = {I_BYTE1, I_BYTE2};
            next_operand.imm    = I_BYTE2;
            next_operand.cycles = coa_pkg::CYC_LONG;
        end else if (is_bit_op(I_OPCODE)) begin
            next_operand.mode    = coa_pkg::COA_MODE_BIT;
            next_operand.space   = direct_space(I_BYTE1);
            next_operand.addr    = {8'h00, bit_byte(I_BYTE1)};
            next_operand.bit_idx = I_BYTE1[2:0];
            next_operand.cycles  = coa_pkg::CYC_LONG;
        end else if (is_carry_op(I_OPCODE)) begin
            next_operand.mode  = coa_pkg::COA_MODE_REG_SPECIFIC;
            next_operand.space = coa_pkg::COA_SPACE_CARRY;
        end else if (is_acc_op(I_OPCODE)) begin
            next_operand.mode  = coa_pkg::COA_MODE_REG_SPECIFIC;
            next_operand.space = coa_pkg::COA_SPACE_ACC;
            next_operand.imm   = I_STATE.acc;
        end else if (I_OPCODE[3]) begin
            // Register number comes from the opcode, bank from the status word.
            next_operand.mode  = coa_pkg::COA_MODE_REGISTER;
            next_operand.space = coa_pkg::COA_SPACE_IRAM;
            next_operand.addr  = reg_window(I_STATE.bank, I_OPCODE[2:0]);
        end else if (I_OPCODE[3:1] == coa_pkg::COL_INDIRECT) begin
            // Index registers arrive already read from the selected bank.
            next_operand.mode   = coa_pkg::COA_MODE_INDIRECT8;
            next_operand.space  = coa_pkg::COA_SPACE_IRAM;
            next_operand.addr   = {8'h00, ri};
            next_operand.cycles = coa_pkg::CYC_LONG;
        end else if (I_OPCODE[3:0] == coa_pkg::COL_DIRECT) begin
            next_operand.mode   = coa_pkg::COA_MODE_DIRECT;
            next_operand.space  = direct_space(I_BYTE1);
            next_operand.addr   = {8'h00, I_BYTE1};
            next_operand.cycles = coa_pkg::CYC_RMW;
        end else if (I_OPCODE[3:0] == coa_pkg::COL_IMM_ACC) begin
            // The constant is passed as data; the address field stays zero.
            next_operand.mode   = coa_pkg::COA_MODE_IMMEDIATE;
            next_operand.imm    = I_BYTE1;
            next_operand.cycles = coa_pkg::CYC_LONG;
        end
    end

    // A single pipeline stage; each decode issues one to three cycles of work.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_VALID <= 1'b0;
        end else if (core_reset) begin
            O_VALID <= 1'b0;
        end else begin
            O_VALID <= I_VALID;
        end
    end

    // The operand holds between requests so a stalled consumer can still read it.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_OPERAND <= '0;
        end else if (core_reset) begin
            O_OPERAND <= '0;
        end else if (I_VALID) begin
            O_OPERAND <= next_operand;
        end
    end

    // The reset flag is registered once more so the consumer sees it in the same cycle as the valid drop.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_CORE_RESET <= 1'b1;
        end else begin
            O_CORE_RESET <= core_reset;
        end
    end
endmodule : coa_operand_decoder

// File: verif/coa_assertions.sv
// Port-level checker for the operand addressing decoder.
`timescale 1ns/1ps
module coa_checker #(
    parameter int SYNC_STAGES = 2
) (
    // Clock, reset and reset pins
    input wire logic                    I_CLK_SYS,
    input wire logic                    I_RST,
    input wire logic                    I_EXT_RESET_N,
    input wire logic                    I_ALT_RESET_N,
    input wire logic                    I_ALT_RESET_EN,
    // Request side
    input wire logic                    I_VALID,
    input wire logic [7:0]              I_OPCODE,
    input wire logic [7:0]              I_BYTE1,
    input wire logic [7:0]              I_BYTE2,
    input wire coa_pkg::coa_cpu_state_t I_STATE,
    // Answer side
    input wire logic                    O_VALID,
    input wire coa_pkg::coa_operand_t   O_OPERAND,
    input wire logic                    O_CORE_RESET
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // A request during a pin reset may be dropped, so decode checks accept the reset flag.
    logic take;
    assign take = I_VALID && !O_CORE_RESET;

    property p_quiet; !I_VALID |=> !O_VALID; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_ext; !I_EXT_RESET_N [*3] |-> ##[0:3] O_CORE_RESET; endproperty
    a_ext: assert property (p_ext) else $error("pin reset not applied");
    property p_alt; (I_ALT_RESET_EN && !I_ALT_RESET_N) [*3] |-> ##[0:3] O_CORE_RESET; endproperty
    a_alt: assert property (p_alt) else $error("alternate reset not applied");
    property p_hold; O_CORE_RESET |-> !O_VALID; endproperty
    a_hold: assert property (p_hold) else $error("answer during reset");
    property p_answer; take |=> O_VALID || O_CORE_RESET; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_direct; take && I_OPCODE[3:0] == coa_pkg::COL_DIRECT |=> O_CORE_RESET
        || (O_OPERAND.mode == coa_pkg::COA_MODE_DIRECT
            && O_OPERAND.addr == {8'h00, $past(I_BYTE1)});
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");
    property p_reg; take && I_OPCODE[3] |=> O_CORE_RESET
        || (O_OPERAND.mode == coa_pkg::COA_MODE_REGISTER
            && O_OPERAND.addr[4:0] == {$past(I_STATE.bank), $past(I_OPCODE[2:0])});
    endproperty
    a_reg: assert property (p_reg) else $error("register select wrong");
    property p_ind16; take && (I_OPCODE == coa_pkg::OP_MOVX_RD_DP
        || I_OPCODE == coa_pkg::OP_MOVX_WR_DP) |=> O_CORE_RESET
        || (O_OPERAND.mode == coa_pkg::COA_MODE_INDIRECT16
            && O_OPERAND.addr == $past(I_STATE.data_pointer));
    endproperty
    a_ind16: assert property (p_ind16) else $error("pointer address wrong");
    property p_index; take && I_OPCODE == coa_pkg::OP_MOVC_DP |=> O_CORE_RESET
        || (O_OPERAND.space == coa_pkg::COA_SPACE_CODE
            && O_OPERAND.addr == $past(I_STATE.data_pointer) + {8'h00, $past(I_STATE.acc)});
    endproperty
    a_index: assert property (p_index) else $error("indexed address wrong");
    property p_acc; take && I_OPCODE == coa_pkg::OP_CLR_ACC |=> O_CORE_RESET
        || (O_OPERAND.space == coa_pkg::COA_SPACE_ACC && O_OPERAND.imm == $past(I_STATE.acc));
    endproperty
    a_acc: assert property (p_acc) else $error("implied operand wrong");
endmodule : coa_checker

// File: verif/coa_state_model.sv
// Behavioural model of the working registers and pointers behind the decoder.
`timescale 1ns/1ps
module coa_state_model (
    // Architectural values set by the bench
    input  wire logic [1:0]         i_bank,
    input  wire logic [7:0]         i_acc,
    input  wire logic [15:0]        i_data_pointer,
    // State presented to the decoder
    output coa_pkg::coa_cpu_state_t o_state
);
    // Index contents differ per bank, so a stale bank shows as a wrong address.
    assign o_state = '{i_acc, i_data_pointer, 16'h1000, i_bank,
                       {1'b0, i_bank, 5'h10}, {1'b1, i_bank, 5'h03}};
endmodule : coa_state_model

// File: verif/coa_operand_decoder_tb_top.sv
// Self-checking bench for the operand addressing decoder.
`timescale 1ns/1ps
module coa_operand_decoder_tb_top;
    logic                    clk, rst, ext_n, alt_n, alt_en, valid, o_valid, o_core_reset;
    logic [7:0]              op, b1, b2, acc;
    logic [1:0]              bank;
    logic [15:0]             data_ptr;
    coa_pkg::coa_cpu_state_t state;
    coa_pkg::coa_operand_t   operand;
    int                      miscompares = 0;
    int                      check_count = 0;
    int                      cycles = 0;

    coa_state_model coa_state_model_inst (.i_bank(bank), .i_acc(acc), .i_data_pointer(data_ptr),
        .o_state(state));
    coa_operand_decoder #(.SYNC_STAGES(2)) coa_operand_decoder_inst (.I_CLK_SYS(clk),
        .I_RST(rst), .I_EXT_RESET_N(ext_n), .I_ALT_RESET_N(alt_n), .I_ALT_RESET_EN(alt_en),
        .I_VALID(valid), .I_OPCODE(op), .I_BYTE1(b1), .I_BYTE2(b2), .I_STATE(state),
        .O_VALID(o_valid), .O_OPERAND(operand), .O_CORE_RESET(o_core_reset));

    always #20 clk = ~clk;
    // The whole run needs under a hundred cycles; the ceiling only catches a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Called at a falling edge; valid stays up so calls run back to back.
    task automatic xfer(input logic [7:0] o, input logic [7:0] x, input logic [7:0] y,
                        input logic [3:0] m, input logic [2:0] s, input logic [15:0] a);
        op = o;
        b1 = x;
        b2 = y;
        valid = 1'b1;
        @(negedge clk);
        chk("valid", o_valid, 1);
        chk("mode", operand.mode, m);
        if (s !== 3'bxxx) chk("space", operand.space, s);
        if (a !== 16'hxxxx) chk("addr", operand.addr, a);
    endtask : xfer

    task automatic idle;
        valid = 1'b0;
        @(negedge clk);
    endtask : idle

    task automatic wait_out;
        repeat (12) if (o_core_reset !== 1'b0) @(negedge clk);
        chk("core_reset", o_core_reset, 0);
        @(negedge clk);
    endtask : wait_out

    task automatic t_addr;
        bank = 2'h2;
        data_ptr = 16'hABCD;
        xfer(8'h25, 8'h40, 8'h00, 4'h1, 3'h1, 16'h0040);
        xfer(8'hE5, 8'h90, 8'h00, 4'h1, 3'h2, 16'h0090);
        xfer(8'hE6, 8'h00, 8'h00, 4'h2, 3'h1, 16'h0050);
        xfer(8'hE7, 8'h00, 8'h00, 4'h2, 3'h1, 16'h00C3);
        xfer(8'hE2, 8'h00, 8'h00, 4'h2, 3'h3, 16'h0050);
        xfer(8'hE0, 8'h00, 8'h00, 4'h3, 3'h3, 16'hABCD);
        chk("cycles", operand.cycles, coa_pkg::CYC_LONG);
        xfer(8'hF0, 8'h00, 8'h00, 4'h3, 3'h3, 16'hABCD);
        idle();
    endtask : t_addr

    task automatic t_register;
        bank = 2'h3;
        for (int r = 0; r < 8; r++) begin
            xfer(8'hE8 | 8'(r), 8'h00, 8'h00, 4'h4, 3'h1, {11'h000, 2'h3, 3'(r)});
            chk("cycles", operand.cycles, coa_pkg::CYC_SHORT);
        end
        idle();
    endtask : t_register

    task automatic t_values;
        acc = 8'h3C;
        xfer(8'hE4, 8'h00, 8'h00, 4'h5, 3'h5, 16'h0000);
        chk("imm", operand.imm, 8'h3C);
        xfer(8'hC3, 8'h00, 8'h00, 4'h5, 3'h6, 16'h0000);
        xfer(8'h74, 8'hA5, 8'h00, 4'h6, 3'h0, 16'h0000);
        chk("imm", operand.imm, 8'hA5);
        xfer(8'h00, 8'h55, 8'h66, 4'h0, 3'h0, 16'h0000);
        chk("cycles", operand.cycles, coa_pkg::CYC_SHORT);
        xfer(8'h90, 8'h12, 8'h34, 4'h6, 3'h0, 16'h1234);
        chk("imm", operand.imm, 8'h34);
        acc = 8'h20;
        data_ptr = 16'hFFF0;
        xfer(8'h93, 8'h00, 8'h00, 4'h7, 3'h4, 16'h0010);
        xfer(8'h83, 8'h00, 8'h00, 4'h7, 3'h4, 16'h1020);
        xfer(8'hD2, 8'h0B, 8'h00, 4'h8, 3'h1, 16'h0021);
        chk("bit_idx", operand.bit_idx, 3);
        xfer(8'hB2, 8'h7F, 8'h00, 4'h8, 3'h1, 16'h002F);
        chk("bit_idx", operand.bit_idx, 7);
        xfer(8'h20, 8'hE5, 8'h00, 4'h8, 3'h2, 16'h00E0);
        chk("bit_idx", operand.bit_idx, 5);
        idle();
    endtask : t_values

    task automatic t_reset;
        ext_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("core_reset", o_core_reset, 1);
        valid = 1'b1;
        op = 8'h25;
        @(negedge clk);
        chk("dropped", o_valid, 0);
        valid = 1'b0;
        ext_n = 1'b1;
        wait_out();
        alt_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("alt_off", o_core_reset, 0);
        alt_en = 1'b1;
        repeat (6) @(negedge clk);
        chk("alt_on", o_core_reset, 1);
        alt_n = 1'b1;
        wait_out();
    endtask : t_reset

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {ext_n, alt_n, alt_en, valid} = 4'hC;
        {op, b1, b2, acc, bank, data_ptr} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        wait_out();
        t_addr();
        t_register();
        t_values();
        t_reset();
        stop_test();
    end
endmodule : coa_operand_decoder_tb_top

bind coa_operand_decoder coa_checker #(.SYNC_STAGES(SYNC_STAGES)) coa_checker_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_EXT_RESET_N(I_EXT_RESET_N),
    .I_ALT_RESET_N(I_ALT_RESET_N), .I_ALT_RESET_EN(I_ALT_RESET_EN), .I_VALID(I_VALID),
    .I_OPCODE(I_OPCODE), .I_BYTE1(I_BYTE1), .I_BYTE2(I_BYTE2), .I_STATE(I_STATE),
    .O_VALID(O_VALID), .O_OPERAND(O_OPERAND), .O_CORE_RESET(O_CORE_RESET));
